// file: rtl/gpp_params.svh
// Constants for the two-port pin control block: offsets, reset values.
// Assumes a 32-bit AXI4-Lite slave; offsets are register indices (x4).
// Notes on behaviour
// - Port six: eight bits, per-bit direction.
// - Port six latch sets level and pull-up.
// - Port six input reads pin levels, inverted when select, latch, direction are all one.
// - Select, latch, direction all one: open, inverted read.
// - Select zero: open, pull-up, or driven latch.
// - Select one: slow latch drive, or driven low.
// - Analog inputs see pin level, never inverted.
// - Port six holds pin state during standby.
// - Port four holds pin state during standby.
// - Port four select A zero behaves like six.
// - Plain port four bits follow the A-one table.
// - Bits 0,1 feed interrupts, inverted like read.
// - Bit 3 outputs serial data, four styles.
// - Bit 4 outputs serial data, feeds data input.
// - Bit 5 outputs serial clock, feeds clock input.
// - Bit 6 outputs first PWM, no input.
// - Bit 7 outputs second PWM, same codes.
// - Shared inputs take pin data, not latch.
// - Port four registers at fixed offsets, reset zero.
`ifndef GPP_PARAMS_SVH
`define GPP_PARAMS_SVH
// Register indices; byte address is four times the index
`define GPP_IDX_P4_LAT  16'h7f50
`define GPP_IDX_P4_IN   16'h7f51
`define GPP_IDX_P4_DIR  16'h7f52
`define GPP_IDX_P4_SELA 16'h7f53
`define GPP_IDX_P4_SELB 16'h7ff4
`define GPP_IDX_P6_LAT  16'h7f58
`define GPP_IDX_P6_IN   16'h7f59
`define GPP_IDX_P6_DIR  16'h7f5a
`define GPP_IDX_P6_SEL  16'h7ff6
// Control registers clear to zero
`define GPP_RST_VAL     8'h00
`endif

// file: rtl/gpp_pkg.sv
// Types for the two-port pin control block.
// Assumes gpp_params.svh is included by the user of the package.
package gpp_pkg;
  // Pin drive style chosen per bit
  typedef enum logic [2:0] {
    GPP_OPEN, GPP_PULLUP, GPP_DRIVE, GPP_SLOW, GPP_ODRAIN
  } gpp_drive_t;
  // Slave answer state for reads
  typedef enum logic {GPP_R_IDLE, GPP_R_RESP} gpp_rd_t;
endpackage

// file: rtl/gpp_port_pair.sv
// Pin control for port four and port six with an AXI4-Lite slave.
// Assumes pin inputs synchronous to clk; pad cells apply pull and slew.
`timescale 1ns/10ps
`default_nettype none
`include "gpp_params.svh"
module gpp_port_pair
  import gpp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // AXI4-Lite write
  input  wire logic [17:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [17:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Standby request: high while halt, hold or clock-keeping standby
  input  wire logic        standby,
  // Port four pins
  input  wire logic [7:0]  p4_pin_in,
  output logic [7:0]       p4_pin_out,
  output logic [7:0]       p4_pin_oe,
  output logic [7:0]       p4_pull_up,
  output logic [7:0]       p4_slow,
  // Port six pins
  input  wire logic [7:0]  p6_pin_in,
  output logic [7:0]       p6_pin_out,
  output logic [7:0]       p6_pin_oe,
  output logic [7:0]       p6_pull_up,
  output logic [7:0]       p6_slow,
  // On-chip peripheral signals
  input  wire logic        serial_unit_b_data_out,
  input  wire logic        serial_unit_b_clk_out,
  input  wire logic        pwm_unit_first_output,
  input  wire logic        pwm_unit_second_output,
  output logic             external_interrupt_line_a,
  output logic             external_interrupt_line_b,
  output logic             serial_unit_b_data_in,
  output logic             serial_unit_b_clk_in,
  output logic [7:0]       analog_converter_input
);

  // Control registers
  logic [7:0] p4_lat_r;   // Port four output latch
  logic [7:0] p4_dir_r;   // Port four direction
  logic [7:0] p4_sela_r;  // Port four select A
  logic [7:0] p4_selb_r;  // Port four select B
  logic [7:0] p6_lat_r;   // Port six output latch
  logic [7:0] p6_dir_r;   // Port six direction
  logic [7:0] p6_sel_r;   // Port six function select
  // Pin decode results
  logic [7:0] p4_out_nxt, p4_oe_nxt, p4_pu_nxt, p4_slow_nxt, p4_inv;
  logic [7:0] p6_out_nxt, p6_oe_nxt, p6_pu_nxt, p6_slow_nxt, p6_inv;
  logic [7:0] p4_alt;     // Peripheral output per port four bit
  // Bus state
  logic       aw_held_r, w_held_r;
  logic [15:0] aw_idx_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  gpp_rd_t     rd_st_r;

  // Address to index: byte address over four
  function automatic logic [15:0] idx_of(input logic [17:0] a);
    idx_of = a[17:2];
  endfunction

  // Decode one pin: {out, oe, pull, slow, inv}
  // Port six uses sela=0 with its select as selb.
  function automatic logic [4:0] pin_dec(input logic sa, input logic sb,
                                         input logic lat, input logic dir,
                                         input logic alt);
    gpp_drive_t m;
    logic o;
    logic inv;
    m = GPP_OPEN;
    o = 1'b0;
    inv = 1'b0;
    case ({sa, sb, lat, dir})
      4'b0000: m = GPP_OPEN;
      4'b0010: m = GPP_PULLUP;
      4'b0001: begin m = GPP_DRIVE; o = 1'b0; end
      4'b0011: begin m = GPP_DRIVE; o = 1'b1; end
      4'b0100: begin m = GPP_SLOW; o = 1'b0; end
      4'b0110: begin m = GPP_SLOW; o = 1'b1; end
      4'b0101: begin m = GPP_DRIVE; o = 1'b0; end
      4'b0111: begin m = GPP_OPEN; inv = 1'b1; end
      4'b1000: begin m = GPP_DRIVE; o = 1'b0; end
      4'b1010: begin m = GPP_DRIVE; o = ~alt; inv = 1'b1; end
      4'b1001: begin m = GPP_DRIVE; o = alt; end
      4'b1011: begin m = GPP_DRIVE; o = 1'b1; end
      4'b1100: begin m = GPP_SLOW; o = 1'b0; end
      4'b1110: begin m = GPP_SLOW; o = alt; end
      4'b1101: begin m = GPP_ODRAIN; o = alt; end
      default: m = GPP_OPEN;
    endcase
    // Open drain pulls low only; high is released
    pin_dec = {o & (m != GPP_ODRAIN),
               (m == GPP_DRIVE) | (m == GPP_SLOW) | ((m == GPP_ODRAIN) & ~alt),
               m == GPP_PULLUP, m == GPP_SLOW, inv};
  endfunction

  // Peripheral outputs; plain bits carry high so 1010 drives low, 1001 high
  assign p4_alt = {pwm_unit_second_output, pwm_unit_first_output,
                   serial_unit_b_clk_out, serial_unit_b_data_out,
                   serial_unit_b_data_out, 3'b111};

  // Per-bit decode of both ports
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      // Port four: select A zero falls back to the port six table
      assign {p4_out_nxt[g], p4_oe_nxt[g], p4_pu_nxt[g], p4_slow_nxt[g], p4_inv[g]} =
        pin_dec(p4_sela_r[g], p4_selb_r[g], p4_lat_r[g], p4_dir_r[g], p4_alt[g]);
      // Port six: one select bit, each bit its own direction
      assign {p6_out_nxt[g], p6_oe_nxt[g], p6_pu_nxt[g], p6_slow_nxt[g], p6_inv[g]} =
        pin_dec(1'b0, p6_sel_r[g], p6_lat_r[g], p6_dir_r[g], 1'b1);
    end
  endgenerate

  // Pin drive registers; frozen while in standby
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      p4_pin_out <= 8'h00;
      p4_pin_oe  <= 8'h00;
      p4_pull_up <= 8'h00;
      p4_slow    <= 8'h00;
      p6_pin_out <= 8'h00;
      p6_pin_oe  <= 8'h00;
      p6_pull_up <= 8'h00;
      p6_slow    <= 8'h00;
    end else if (!standby) begin
      p4_pin_out <= p4_out_nxt;
      p4_pin_oe  <= p4_oe_nxt;
      p4_pull_up <= p4_pu_nxt;
      p4_slow    <= p4_slow_nxt;
      p6_pin_out <= p6_out_nxt;
      p6_pin_oe  <= p6_oe_nxt;
      p6_pull_up <= p6_pu_nxt;
      p6_slow    <= p6_slow_nxt;
    end // Standby keeps the entry state
  end

  // Shared inputs: pin data; port four ones inverted exactly where the read is inverted, analog never
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      external_interrupt_line_a <= 1'b0;
      external_interrupt_line_b <= 1'b0;
      serial_unit_b_data_in     <= 1'b0;
      serial_unit_b_clk_in      <= 1'b0;
      analog_converter_input    <= 8'h00;
    end else begin
      external_interrupt_line_a <= p4_pin_in[0] ^ p4_inv[0];
      external_interrupt_line_b <= p4_pin_in[1] ^ p4_inv[1];
      serial_unit_b_data_in     <= p4_pin_in[4] ^ p4_inv[4];
      serial_unit_b_clk_in      <= p4_pin_in[5] ^ p4_inv[5];
      analog_converter_input    <= p6_pin_in;
    end
  end

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign s_axi_bresp   = 2'b00;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_idx_r  <= 16'h0000;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_idx_r  <= idx_of(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (aw_held_r && w_held_r) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; unmapped and read-only indices ignore the data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      p4_lat_r  <= `GPP_RST_VAL;
      p4_dir_r  <= `GPP_RST_VAL;
      p4_sela_r <= `GPP_RST_VAL;
      p4_selb_r <= `GPP_RST_VAL;
      p6_lat_r  <= `GPP_RST_VAL;
      p6_dir_r  <= `GPP_RST_VAL;
      p6_sel_r  <= `GPP_RST_VAL;
    end else if (aw_held_r && w_held_r && wstrb_r[0]) begin
      case (aw_idx_r)
        `GPP_IDX_P4_LAT:  p4_lat_r  <= wdata_r[7:0];
        `GPP_IDX_P4_DIR:  p4_dir_r  <= wdata_r[7:0];
        `GPP_IDX_P4_SELA: p4_sela_r <= wdata_r[7:0];
        `GPP_IDX_P4_SELB: p4_selb_r <= wdata_r[7:0];
        `GPP_IDX_P6_LAT:  p6_lat_r  <= wdata_r[7:0];
        `GPP_IDX_P6_DIR:  p6_dir_r  <= wdata_r[7:0];
        `GPP_IDX_P6_SEL:  p6_sel_r  <= wdata_r[7:0];
        default: ;
      endcase
    end
  end

  // Read channel: one read at a time, answer one cycle after address
  assign s_axi_arready = (rd_st_r == GPP_R_IDLE);
  assign s_axi_rvalid  = (rd_st_r == GPP_R_RESP);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_st_r     <= GPP_R_IDLE;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      case (rd_st_r)
        GPP_R_IDLE: begin
          if (s_axi_arvalid) begin
            rd_st_r     <= GPP_R_RESP;
            s_axi_rresp <= 2'b00;
            case (idx_of(s_axi_araddr))
              `GPP_IDX_P4_LAT:  s_axi_rdata <= {24'h0, p4_lat_r};
              `GPP_IDX_P4_IN:   s_axi_rdata <= {24'h0, p4_pin_in ^ p4_inv};
              `GPP_IDX_P4_DIR:  s_axi_rdata <= {24'h0, p4_dir_r};
              `GPP_IDX_P4_SELA: s_axi_rdata <= {24'h0, p4_sela_r};
              `GPP_IDX_P4_SELB: s_axi_rdata <= {24'h0, p4_selb_r};
              `GPP_IDX_P6_LAT:  s_axi_rdata <= {24'h0, p6_lat_r};
              `GPP_IDX_P6_IN:   s_axi_rdata <= {24'h0, p6_pin_in ^ p6_inv};
              `GPP_IDX_P6_DIR:  s_axi_rdata <= {24'h0, p6_dir_r};
              `GPP_IDX_P6_SEL:  s_axi_rdata <= {24'h0, p6_sel_r};
              default: begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= 2'b10;  // Unmapped: slave error
              end
            endcase
          end
        end
        GPP_R_RESP: if (s_axi_rready) rd_st_r <= GPP_R_IDLE;
        default: rd_st_r <= GPP_R_IDLE;
      endcase
    end
  end

  // Checks; each property looks one edge ahead, so pad values are judged
  // after the registered decode. Properties that must hold in standby show
  // it by leaving standby out of their antecedent.
  // A completed write to the port four latch
  sequence s_wr_port_four_output_latch;
    aw_held_r && w_held_r && wstrb_r[0] && aw_idx_r == `GPP_IDX_P4_LAT;
  endsequence

  // A completed write to the port six direction register
  sequence s_wr_p6dir;
    aw_held_r && w_held_r && wstrb_r[0] && aw_idx_r == `GPP_IDX_P6_DIR;
  endsequence

  p6_all_one_a: assert property (@(posedge clk) disable iff (!rstn)
    (p6_sel_r[0] && p6_lat_r[0] && p6_dir_r[0] && !standby) |=> !p6_pin_oe[0])
    else $error("port six inverted mode drives pin");
  p6_drive_a: assert property (@(posedge clk) disable iff (!rstn)
    (!p6_sel_r[2] && p6_dir_r[2] && !standby) |=> p6_pin_oe[2] && p6_pin_out[2] == $past(p6_lat_r[2]))
    else $error("port six driven bit wrong level");
  p6_pullup_a: assert property (@(posedge clk) disable iff (!rstn)
    (!p6_sel_r[1] && p6_lat_r[1] && !p6_dir_r[1] && !standby) |=> p6_pull_up[1] && !p6_pin_oe[1])
    else $error("port six pull-up not enabled");
  p6_slow_a: assert property (@(posedge clk) disable iff (!rstn)
    (p6_sel_r[3] && !p6_dir_r[3] && !standby) |=> p6_slow[3] && p6_pin_oe[3])
    else $error("port six slow drive missing");
  // Sampled reset in the antecedent keeps the edge that leaves reset out
  analog_pass_a: assert property (@(posedge clk) disable iff (!rstn)
    rstn |=> analog_converter_input == $past(p6_pin_in))
    else $error("analog input not pin level");
  standby_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    standby |=> $stable(p6_pin_oe) && $stable(p6_pin_out) && $stable(p4_pin_oe))
    else $error("pins changed in standby");
  p4_standby_a: assert property (@(posedge clk) disable iff (!rstn)
    standby [*2] |=> $stable(p4_pin_out) && $stable(p4_pull_up))
    else $error("port four changed in standby");
  int_invert_a: assert property (@(posedge clk) disable iff (!rstn)
    (p4_sela_r[0] && !p4_selb_r[0] && p4_lat_r[0] && !p4_dir_r[0])
      |=> external_interrupt_line_a == !$past(p4_pin_in[0]))
    else $error("interrupt line not inverted");
  pwm_cmos_a: assert property (@(posedge clk) disable iff (!rstn)
    (p4_sela_r[6] && !p4_selb_r[6] && !p4_lat_r[6] && p4_dir_r[6] && !standby)
      |=> p4_pin_out[6] == $past(pwm_unit_first_output))
    else $error("pwm output not routed");
  dir_write_a: assert property (@(posedge clk) disable iff (!rstn)
    s_wr_p6dir |=> p6_dir_r == $past(wdata_r[7:0]))
    else $error("direction write lost");

  // Inverted CMOS on bit 5 hands the clock input the inverted pin
  clk_invert_a: assert property (@(posedge clk) disable iff (!rstn)
    (p4_sela_r[5] && !p4_selb_r[5] && p4_lat_r[5] && !p4_dir_r[5])
      |=> serial_unit_b_clk_in == !$past(p4_pin_in[5]))
    else $error("serial clock input not inverted");
  // Both selects clear: the data input follows the pin, never the latch
  data_plain_a: assert property (@(posedge clk) disable iff (!rstn)
    (rstn && !p4_sela_r[4] && !p4_selb_r[4])
      |=> serial_unit_b_data_in == $past(p4_pin_in[4]))
    else $error("serial data input not pin level");
  // Open drain on bit 3 sinks only while the serial data is low
  serial_drain_a: assert property (@(posedge clk) disable iff (!rstn)
    (p4_sela_r[3] && p4_selb_r[3] && !p4_lat_r[3] && p4_dir_r[3] && !standby)
      |=> !p4_pin_out[3] && p4_pin_oe[3] == !$past(serial_unit_b_data_out))
    else $error("serial data open drain wrong");
  // Inverted CMOS on bit 7 drives the second pwm output inverted
  pwm_invert_a: assert property (@(posedge clk) disable iff (!rstn)
    (p4_sela_r[7] && !p4_selb_r[7] && p4_lat_r[7] && !p4_dir_r[7] && !standby)
      |=> p4_pin_oe[7] && p4_pin_out[7] == !$past(pwm_unit_second_output))
    else $error("second pwm not inverted");
  // A plain bit in the inverted-read code still drives low
  plain_low_a: assert property (@(posedge clk) disable iff (!rstn)
    (p4_sela_r[2] && !p4_selb_r[2] && p4_lat_r[2] && !p4_dir_r[2] && !standby)
      |=> p4_pin_oe[2] && !p4_pin_out[2])
    else $error("plain bit not driven low");
  // A completed latch write lands on the next edge
  lat_write_a: assert property (@(posedge clk) disable iff (!rstn)
    s_wr_port_four_output_latch |=> p4_lat_r == $past(wdata_r[7:0]))
    else $error("port four latch write lost");
  // A pin read with no inversion returns the level at the address edge
  pin_read_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_axi_arvalid && s_axi_arready && !p6_sel_r[0] &&
     s_axi_araddr[17:2] == `GPP_IDX_P6_IN)
      |=> s_axi_rvalid && s_axi_rdata[0] == $past(p6_pin_in[0]))
    else $error("pin read not pin level");
endmodule
`default_nettype wire

// file: tb/gpp_pin_board.sv
// Board circuitry on one eight-bit port: weak sources, pull-ups, floating pins.
// Assumes the pad controls of the pin block; one clock.
`timescale 1ns/10ps
`default_nettype none
module gpp_pin_board (
  // Clock
  input  wire logic       clk,
  // Pad controls from the device
  input  wire logic [7:0] oe,
  input  wire logic [7:0] out,
  input  wire logic [7:0] pu,
  // Board sources through series resistors, weaker than a pad driver
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext,
  // Resolved pin levels
  output logic      [7:0] pin
);
  logic [7:0] tog_r = 8'h55; // Floating level wanders so no stale value looks valid
  // Floating pattern changes every cycle
  always_ff @(posedge clk) begin
    tog_r <= ~tog_r;
  end
  // Pad driver wins, then board source, then pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin[i] = oe[i] ? out[i] : ext_en[i] ? ext[i] : pu[i] ? 1'b1 : tog_r[i];
    end
  end
endmodule
`default_nettype wire

// file: tb/test_gpp_port_pair.sv
// Self-checking bench for the two-port pin control block.
// Assumes the slave and pad timing of the pin block; a board model on each port.
`timescale 1ns/10ps
`default_nettype none
`include "gpp_params.svh"
module test_gpp_port_pair;
  // Design signals, named as the ports
  logic        clk, rstn, standby, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, external_interrupt_line_a, external_interrupt_line_b;
  logic        serial_unit_b_data_in, serial_unit_b_clk_in;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, fo, xf, xfm;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  p4_pin_in, p4_pin_out, p4_pin_oe, p4_pull_up, p4_slow, analog_converter_input;
  logic [7:0]  p6_pin_in, p6_pin_out, p6_pin_oe, p6_pull_up, p6_slow, en4, ex4, en6, ex6;
  // Model registers and expected pad state (x*: expected, xm*: pin level known)
  logic [7:0]  mr [9];
  logic [7:0]  xoe4, xo4, xu4, xs4, xi4, xp4, xm4, xoe6, xo6, xu6, xs6, xi6, xp6, xm6;
  int          err_count, checks_done;
  wire  [3:0]  fi = {serial_unit_b_clk_in, serial_unit_b_data_in, external_interrupt_line_b,
                     external_interrupt_line_a};
  // Register indices in bus order; byte address is index times four
  localparam logic [15:0] IDX [9] = '{`GPP_IDX_P4_LAT, `GPP_IDX_P4_IN, `GPP_IDX_P4_DIR,
    `GPP_IDX_P4_SELA, `GPP_IDX_P4_SELB, `GPP_IDX_P6_LAT, `GPP_IDX_P6_IN, `GPP_IDX_P6_DIR,
    `GPP_IDX_P6_SEL};
  gpp_port_pair uut (
    .clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .standby, .p4_pin_in, .p4_pin_out, .p4_pin_oe, .p4_pull_up, .p4_slow, .p6_pin_in,
    .p6_pin_out, .p6_pin_oe, .p6_pull_up, .p6_slow, .serial_unit_b_data_out(fo[0]),
    .serial_unit_b_clk_out(fo[1]), .pwm_unit_first_output(fo[2]),
    .pwm_unit_second_output(fo[3]), .external_interrupt_line_a, .external_interrupt_line_b,
    .serial_unit_b_data_in, .serial_unit_b_clk_in, .analog_converter_input);
  // Board circuitry on each port
  gpp_pin_board b4 (.clk, .oe(p4_pin_oe), .out(p4_pin_out), .pu(p4_pull_up), .ext_en(en4),
    .ext(ex4), .pin(p4_pin_in));
  gpp_pin_board b6 (.clk, .oe(p6_pin_oe), .out(p6_pin_out), .pu(p6_pull_up), .ext_en(en6),
    .ext(ex6), .pin(p6_pin_in));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Style of one bit from {A,B,latch,dir}: {inv read, oe, out, pull-up, slow}
  function automatic logic [4:0] sty(input logic [3:0] c, input logic fn, input logic f);
    case (c)
      4'b0010: sty = 5'b00010;
      4'b0001, 4'b0101, 4'b1000: sty = 5'b01000;
      4'b0011, 4'b1011: sty = 5'b01100;
      4'b0100, 4'b1100: sty = 5'b01001;
      4'b0110: sty = 5'b01101;
      4'b0111: sty = 5'b10000;
      4'b1010: sty = {2'b11, fn & ~f, 2'b00};
      4'b1001: sty = {2'b01, fn ? f : 1'b1, 2'b00};
      4'b1110: sty = {2'b01, fn ? f : 1'b1, 2'b01};
      4'b1101: sty = {1'b0, fn & ~f, 3'b000}; // Open drain only sinks
      default: sty = 5'b00000;
    endcase
  endfunction
  // Expected pads, pin levels and shared inputs from the model registers
  task automatic calc();
    for (int i = 0; i < 8; i++) begin
      {xi4[i], xoe4[i], xo4[i], xu4[i], xs4[i]} =
        sty({mr[3][i], mr[4][i], mr[0][i], mr[2][i]}, i > 2, fo[(i < 5) ? 0 : i - 4]);
      {xi6[i], xoe6[i], xo6[i], xu6[i], xs6[i]} =
        sty({1'b0, mr[8][i], mr[5][i], mr[7][i]}, 1'b0, 1'b0);
    end
    xp4 = xoe4 & xo4 | ~xoe4 & en4 & ex4 | ~xoe4 & ~en4 & xu4;
    xm4 = xoe4 | en4 | xu4;
    xp6 = xoe6 & xo6 | ~xoe6 & en6 & ex6 | ~xoe6 & ~en6 & xu6;
    xm6 = xoe6 | en6 | xu6;
    xf = {xp4[5:4] ^ xi4[5:4], xp4[1:0] ^ xi4[1:0]};
    xfm = {xm4[5:4], xm4[1:0]};
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Pad controls; pin level only where driven
  task automatic pads();
    chk("p4 oe", xoe4, p4_pin_oe);
    chk("p4 out", xo4 & xoe4, p4_pin_out & xoe4);
    chk("p4 pull", xu4, p4_pull_up);
    chk("p4 slow", xs4, p4_slow);
    chk("p6 oe", xoe6, p6_pin_oe);
    chk("p6 out", xo6 & xoe6, p6_pin_out & xoe6);
    chk("p6 pull", xu6, p6_pull_up);
    chk("p6 slow", xs6, p6_slow);
  endtask
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [17:0] a, input logic [7:0] v, input logic [3:0] s);
    logic ta, tw, ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready & !ad;
      tw = s_axi_wvalid & s_axi_wready & !wd;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      ad = ad | ta;
      wd = wd | tw;
    end
    do @(negedge clk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", 32'h0, {30'h0, s_axi_bresp});
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] s);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk); while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask
  // Write every control register from the model
  task automatic cfg();
    for (int k = 0; k < 9; k++) if (k != 1 && k != 6) wr({IDX[k], 2'b00}, mr[k], 4'hf);
  endtask
  // Read back every register, pin reads masked to known levels, then a hole
  task automatic regs();
    logic [31:0] d;
    logic [1:0] s;
    for (int k = 0; k < 9; k++) begin
      rd({IDX[k], 2'b00}, d, s);
      if (k == 1) chk("p4 read", {24'h0, (xp4 ^ xi4) & xm4}, d & {24'hffffff, xm4});
      else if (k == 6) chk("p6 read", {24'h0, (xp6 ^ xi6) & xm6}, d & {24'hffffff, xm6});
      else chk("reg", {24'h0, mr[k]}, d);
      chk("resp", 32'h0, {30'h0, s});
    end
    rd(18'h0, d, s);
    chk("hole data", 32'h0, d);
    chk("hole resp", 32'h2, {30'h0, s});
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog: the whole run needs well under this many cycles
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    $display("CHECK FAILED watchdog expected end seen hang");
    end_sim();
  end
  initial begin
    {rstn, standby, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, fo} = '0;
    {en4, ex4, en6, ex6} = '0;
    err_count = 0;
    checks_done = 0;
    foreach (mr[k]) mr[k] = 8'h00;
    void'($urandom(63049));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    calc();
    pads();
    regs();
    // Every code on every bit first, then random settings
    for (int k = 0; k < 40; k++) begin
      for (int i = 0; i < 8; i++) begin
        {mr[3][i], mr[4][i], mr[0][i], mr[2][i]} = (k < 16) ? 4'(k + i) : 4'($urandom);
        {mr[8][i], mr[5][i], mr[7][i]} = (k < 16) ? 3'(k + 2 * i) : 3'($urandom);
      end
      fo <= 4'($urandom);
      {en4, ex4, en6, ex6} <= $urandom;
      cfg();
      repeat (4) @(negedge clk);
      calc();
      pads();
      chk("shared in", xf & xfm, fi & xfm);
      chk("analog", xp6 & xm6, analog_converter_input & xm6);
      regs();
    end
    // Write with byte lane 0 off leaves the latch alone
    wr({IDX[0], 2'b00}, ~mr[0], 4'h0);
    regs();
    // Standby freezes pads while registers and functions change
    standby <= 1'b1;
    mr[0] = ~mr[0];
    mr[5] = ~mr[5];
    cfg();
    fo <= ~fo;
    repeat (4) @(negedge clk);
    pads();
    @(posedge clk);
    standby <= 1'b0;
    calc();
    repeat (4) @(negedge clk);
    pads();
    end_sim();
  end
endmodule
`default_nettype wire
